// file: inc/loop_detector_regs.vh
// Purpose: constants for the loop detector channel timing block
// Assumes: 40 MHz ref_clk, two channels, quarter-second timebase
// Notes:   tune and hold times are literal tick counts; only the cycle count per tick derives from other constants
`ifndef LOOP_DETECTOR_REGS_VH
`define LOOP_DETECTOR_REGS_VH

// ----------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------
`define CLK_KHZ          40000
`define TICK_MS          250
`define TICK_CYCLES      (`CLK_KHZ * `TICK_MS)

// ----------------------------------------------------------------
// tuning and call hold, in quarter-second ticks
// ----------------------------------------------------------------
// tuning takes 2 s, well inside the 10 s allowed
`define TUNE_TICKS       4'h8
// class 2 hold: 4 minutes
`define HOLD2_TICKS      15'h03C0
// class 3 hold: 60 minutes, inside the 30..120 minute window
`define HOLD3_TICKS      15'h3840

// ----------------------------------------------------------------
// delay and extend limits
// ----------------------------------------------------------------
// delay in whole seconds, 0..30
`define DELAY_MAX_S      6'h1E
// extend in quarter seconds, 0..60 (15 s)
`define EXTEND_MAX_Q     6'h3C

// ----------------------------------------------------------------
// detection thresholds
// ----------------------------------------------------------------
// level 0 trips at base/8, level 7 at base/1024
`define SENS_BASE_SHIFT  4'h3
// a drop of base/4 (25 percent) is a loop fault
`define FAULT_SHIFT      4'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BASE         16'h0000
`define RST_TIMER        8'h00

`endif

// file: hdl/loop_detector_channel_timing.v
// Purpose: two-channel inductive loop detector call logic with delay/extend timing
// Assumes: measCount is the loop oscillator count of the channel on scanSel, same clock domain;
//          a fall of measCount mirrors a fall of loop inductance
// Notes:   all panel and fault pins pass a two-stage synchroniser
//
// Summary of operation
// - channels are measured one after another in a repeating scan.
// - a channel switched off from the panel never produces a call.
// - each channel has eight selectable sensitivity levels.
// - class 2 channels hold a present vehicle's call 4 minutes from detection, delay time included.
// - class 3 channels hold a present vehicle's call 30 to 120 minutes.
// - call delay adjustable 0 to 30 seconds in one-second steps.
// - call extension adjustable 0 to 15 seconds in quarter-second steps.
// - delay and extend can both be on; delay runs first, then extend.
// - actuation during extend passes at once without a new delay.
// - call is forced on while tuning, during a loop fault, or power loss.
// - after power returns each channel tunes within 10 seconds.
// - after a loop fault clears the channel retunes within 10 seconds.
// - fault indicator latches until a manual reset.
// - faults are open loop, short to ground, 25 percent inductance drop.
// - two channels on one loop still work normally.
`include "loop_detector_regs.vh"

module loop_detector_channel_timing #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES
)(
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        measValid,
  input  wire [15:0] measCount,
  input  wire [1:0]  chEnable,
  input  wire [5:0]  sensLevel,
  input  wire [1:0]  classSel,
  input  wire [9:0]  delaySec,
  input  wire [11:0] extendQtr,
  input  wire [1:0]  openFault,
  input  wire [1:0]  groundFault,
  input  wire        powerOk,
  input  wire        manualReset,
  output wire [1:0]  callOut,
  output wire [1:0]  faultInd,
  output wire [1:0]  tuning,
  output wire        scanSel
);

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [1:0] T_IDLE   = 2'b00;
  localparam [1:0] T_DELAY  = 2'b01;
  localparam [1:0] T_ON     = 2'b10;
  localparam [1:0] T_EXTEND = 2'b11;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [15:0] lossOf;
    input [15:0] base;
    input [15:0] meas;
    begin
      lossOf = (meas < base) ? (base - meas) : 16'h0000;
    end
  endfunction

  function [5:0] clampTo;
    input [5:0] val;
    input [5:0] lim;
    begin
      clampTo = (val > lim) ? lim : val;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  wire [37:0] pinRaw = {manualReset, powerOk, groundFault, openFault, extendQtr,
                        delaySec, classSel, sensLevel, chEnable};
  reg  [37:0] pinMeta_reg;
  reg  [37:0] pinSync_reg;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      pinMeta_reg <= 38'h00_0000_0000;
      pinSync_reg <= 38'h00_0000_0000;
    end
    else
    begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  wire [1:0]  enS     = pinSync_reg[1:0];
  wire [5:0]  sensS   = pinSync_reg[7:2];
  wire [1:0]  classS  = pinSync_reg[9:8];
  wire [9:0]  delayS  = pinSync_reg[19:10];
  wire [11:0] extendS = pinSync_reg[31:20];
  wire [1:0]  openS   = pinSync_reg[33:32];
  wire [1:0]  groundS = pinSync_reg[35:34];
  wire        powerS  = pinSync_reg[36];
  wire        mresetS = pinSync_reg[37];

  // ----------------------------------------------------------------
  // quarter-second timebase
  // ----------------------------------------------------------------
  reg [23:0] tickCnt_reg;
  reg        tick_reg;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      tickCnt_reg <= 24'h00_0000;
      tick_reg    <= 1'b0;
    end
    else if (tickCnt_reg == TICK_CYCLES - 24'h00_0001)
    begin
      tickCnt_reg <= 24'h00_0000;
      tick_reg    <= 1'b1;
    end
    else
    begin
      tickCnt_reg <= tickCnt_reg + 24'h00_0001;
      tick_reg    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-channel state
  // ----------------------------------------------------------------
  reg [15:0] base_reg     [0:1];
  reg [15:0] lastMeas_reg [0:1];
  reg [7:0]  tCnt_reg     [0:1];
  reg [14:0] holdCnt_reg  [0:1];
  reg [3:0]  tuneCnt_reg  [0:1];
  reg [1:0]  tState_reg   [0:1];
  reg [1:0]  run_reg;
  reg [1:0]  det_reg;
  reg [1:0]  dropF_reg;
  reg [1:0]  callOut_reg;
  reg [1:0]  faultInd_reg;
  reg [1:0]  tuning_reg;
  reg        scanSel_reg;
  reg [15:0] loss         [0:1];
  reg [5:0]  dlySec       [0:1];
  reg [5:0]  extQ         [0:1];
  reg [14:0] holdLim      [0:1];
  reg [1:0]  sample;
  reg [1:0]  faultNow;
  reg [1:0]  qual;
  integer    i;
  integer    c;

  assign callOut  = callOut_reg;
  assign faultInd = faultInd_reg;
  assign tuning   = tuning_reg;
  assign scanSel  = scanSel_reg;

  always @*
  begin
    for (c = 0; c < 2; c = c + 1)
    begin
      // own baseline per channel, so a shared loop gives two independent readings
      sample[c]   = measValid && (scanSel_reg == c[0]);
      loss[c]     = lossOf(base_reg[c], measCount);
      dlySec[c]   = clampTo({1'b0, delayS[c*5 +: 5]}, `DELAY_MAX_S);
      extQ[c]     = clampTo(extendS[c*6 +: 6], `EXTEND_MAX_Q);
      holdLim[c]  = classS[c] ? `HOLD3_TICKS : `HOLD2_TICKS;
      faultNow[c] = openS[c] | groundS[c] | dropF_reg[c];
      qual[c]     = (tState_reg[c] == T_ON) || (tState_reg[c] == T_EXTEND);
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      scanSel_reg  <= 1'b0;
      run_reg      <= 2'b00;
      det_reg      <= 2'b00;
      dropF_reg    <= 2'b00;
      callOut_reg  <= 2'b00;
      faultInd_reg <= 2'b00;
      tuning_reg   <= 2'b00;
      for (i = 0; i < 2; i = i + 1)
      begin
        base_reg[i]     <= `RST_BASE;
        lastMeas_reg[i] <= `RST_BASE;
        tCnt_reg[i]     <= `RST_TIMER;
        holdCnt_reg[i]  <= 15'h0000;
        tuneCnt_reg[i]  <= 4'h0;
        tState_reg[i]   <= T_IDLE;
      end
    end
    else
    begin
      if (measValid)
        scanSel_reg <= ~scanSel_reg;
      for (i = 0; i < 2; i = i + 1)
      begin
        // latched fault, set wins over manual reset
        if (faultNow[i])
          faultInd_reg[i] <= 1'b1;
        else if (mresetS)
          faultInd_reg[i] <= 1'b0;

        if (!enS[i] || !powerS || faultNow[i])
        begin
          run_reg[i]     <= 1'b0;
          tuneCnt_reg[i] <= 4'h0;
          det_reg[i]     <= 1'b0;
          dropF_reg[i]   <= 1'b0;
          holdCnt_reg[i] <= 15'h0000;
          tState_reg[i]  <= T_IDLE;
        end
        else if (!run_reg[i])
        begin
          if (sample[i])
            lastMeas_reg[i] <= measCount;
          // self-tune finishes after a fixed tick count
          if (tick_reg)
          begin
            if (tuneCnt_reg[i] == `TUNE_TICKS - 4'h1)
            begin
              run_reg[i]  <= 1'b1;
              base_reg[i] <= lastMeas_reg[i];
            end
            else
              tuneCnt_reg[i] <= tuneCnt_reg[i] + 4'h1;
          end
        end
        else
        begin
          if (sample[i])
          begin
            dropF_reg[i] <= (loss[i] >= (base_reg[i] >> `FAULT_SHIFT)) && (loss[i] != 16'h0000);
            det_reg[i]   <= (loss[i] != 16'h0000) &&
                            (loss[i] >= (base_reg[i] >> (`SENS_BASE_SHIFT + {1'b0, sensS[i*3 +: 3]})));
          end

          // presence hold: at the limit the vehicle is tuned out
          if (!det_reg[i])
            holdCnt_reg[i] <= 15'h0000;
          else if (tick_reg)
          begin
            if (holdCnt_reg[i] == holdLim[i] - 15'h0001)
            begin
              run_reg[i]     <= 1'b0;
              tuneCnt_reg[i] <= 4'h0;
              det_reg[i]     <= 1'b0;
              holdCnt_reg[i] <= 15'h0000;
              tState_reg[i]  <= T_IDLE;
            end
            else
              holdCnt_reg[i] <= holdCnt_reg[i] + 15'h0001;
          end

          case (tState_reg[i])
            T_IDLE:
            begin
              if (det_reg[i])
              begin
                if (dlySec[i] == 6'h00)
                  tState_reg[i] <= T_ON;
                else
                begin
                  tState_reg[i] <= T_DELAY;
                  tCnt_reg[i]   <= {dlySec[i], 2'b00};
                end
              end
            end
            T_DELAY:
            begin
              if (!det_reg[i])
                tState_reg[i] <= T_IDLE;
              else if (tick_reg)
              begin
                if (tCnt_reg[i] == 8'h01)
                  tState_reg[i] <= T_ON;
                tCnt_reg[i] <= tCnt_reg[i] - 8'h01;
              end
            end
            T_ON:
            begin
              if (!det_reg[i])
              begin
                if (extQ[i] == 6'h00)
                  tState_reg[i] <= T_IDLE;
                else
                begin
                  tState_reg[i] <= T_EXTEND;
                  tCnt_reg[i]   <= {2'b00, extQ[i]};
                end
              end
            end
            T_EXTEND:
            begin
              if (det_reg[i])
                tState_reg[i] <= T_ON;
              else if (tick_reg)
              begin
                if (tCnt_reg[i] == 8'h01)
                  tState_reg[i] <= T_IDLE;
                tCnt_reg[i] <= tCnt_reg[i] - 8'h01;
              end
            end
            default:
              tState_reg[i] <= T_IDLE;
          endcase
        end

        callOut_reg[i] <= enS[i] & (qual[i] | ~run_reg[i] | faultNow[i] | ~powerS);
        tuning_reg[i]  <= enS[i] & ~run_reg[i];
      end
    end
  end

endmodule

// file: testbench/loop_detector_sva.sv
// Purpose: assertions on the scan select and the channel 0 call, tuning and fault pins
// Assumes: panel and fault pins pass two sync stages
// Notes:   channel 1 is the same logic, judged by the bench
module loop_detector_sva #(
  parameter [23:0] TICK_CYCLES = 24'h00_000A
)(
  input logic       ref_clk,
  input logic       srst,
  input logic       measValid,
  input logic [1:0] chEnable,
  input logic [1:0] openFault,
  input logic [1:0] groundFault,
  input logic       powerOk,
  input logic       manualReset,
  input logic [1:0] callOut,
  input logic [1:0] faultInd,
  input logic [1:0] tuning,
  input logic       scanSel
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // a tune is only bounded once nothing keeps restarting it
  logic [31:0] tuneRun_reg;
  always @(posedge ref_clk)
    if (srst || !tuning[0] || !powerOk || openFault[0] || groundFault[0])
      tuneRun_reg <= 32'h0000_0000;
    else
      tuneRun_reg <= tuneRun_reg + 32'h0000_0001;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_off0;
    !chEnable[0] [*4];
  endsequence
  sequence s_open0;
    (openFault[0] && chEnable[0]) [*4];
  endsequence
  sequence s_quiet0;
    !manualReset [*4] ##0 faultInd[0];
  endsequence
  a_scan_toggle: assert property (measValid |=> scanSel != $past(scanSel))
    else $error("scan channel did not advance");
  a_scan_hold: assert property (!measValid |=> $stable(scanSel))
    else $error("scan channel moved without a sample");
  a_off_silent: assert property (s_off0 |-> ##1 (!callOut[0] && !tuning[0]))
    else $error("disabled channel active");
  a_tune_call: assert property (tuning[0] |-> callOut[0])
    else $error("no call while tuning");
  a_fault_sets: assert property (s_open0 |-> faultInd[0] && callOut[0])
    else $error("open loop not flagged");
  a_fault_latch: assert property (s_quiet0 |=> faultInd[0])
    else $error("fault flag lost without reset");
  a_power_call: assert property ((!powerOk && chEnable[0]) [*4] |-> callOut[0])
    else $error("no call without power");
  a_tune_bound: assert property (tuneRun_reg <= 40 * TICK_CYCLES)
    else $error("tuning longer than ten seconds");
endmodule

// file: testbench/signal_controller_model.sv
// Purpose: controller side, counts cycles in which a vehicle call rises
// Assumes: calls are levels in the ref_clk domain
// Notes:   it only listens, so it never loads the detector
module signal_controller_model (
  input  logic       ref_clk,
  input  logic       srst,
  input  logic [1:0] callIn,
  output logic [7:0] callCount
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] prev_reg;
  always @(posedge ref_clk)
    if (srst)
    begin
      prev_reg <= 2'h0;
      callCount <= 8'h00;
    end
    else
    begin
      prev_reg <= callIn;
      if (|(callIn & ~prev_reg))
        callCount <= callCount + 8'h01;
    end
endmodule

// file: testbench/testbench.sv
// Purpose: self-checking bench for the loop detector timing
// Assumes: a tick of 10 cycles keeps the run short
// Notes:   a sample every 4 cycles, count taken per scanned channel
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [23:0] TICK = 24'h00_000A;
  logic        ref_clk = 1'h0, srst = 1'h1, measValid = 1'h0, powerOk = 1'h1, manualReset = 1'h0;
  logic [15:0] measCount = 16'h0000;
  logic [1:0]  chEnable = 2'h0, classSel = 2'h0, openFault = 2'h0, groundFault = 2'h0, div = 2'h0;
  logic [5:0]  sensLevel = 6'h00;
  logic [9:0]  delaySec = 10'h000;
  logic [11:0] extendQtr = 12'h000;
  logic [15:0] cnt [2] = '{16'h1000, 16'h1000};
  logic [1:0]  callOut, faultInd, tuning;
  logic        scanSel;
  logic [7:0]  callCount;
  int          n_mismatch = 0, checked = 0;
  loop_detector_channel_timing #(.TICK_CYCLES(TICK)) i_loop_detector_channel_timing (
    .ref_clk(ref_clk), .srst(srst), .measValid(measValid), .measCount(measCount),
    .chEnable(chEnable), .sensLevel(sensLevel), .classSel(classSel), .delaySec(delaySec),
    .extendQtr(extendQtr), .openFault(openFault), .groundFault(groundFault), .powerOk(powerOk),
    .manualReset(manualReset), .callOut(callOut), .faultInd(faultInd), .tuning(tuning),
    .scanSel(scanSel));
  signal_controller_model i_signal_controller_model (
    .ref_clk(ref_clk), .srst(srst), .callIn(callOut), .callCount(callCount));
  initial
    forever #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
  begin
    div = div + 2'h1;
    measValid = (div == 2'h0) && !srst;
    measCount = cnt[scanSel];
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // tun set: wait for all tuning to end, else for callOut[ch] == v
  task automatic wait_for(input int ch, input logic v, input int lim, input logic tun);
    int k;
    k = 0;
    while (((tun ? |tuning : callOut[ch]) !== v) && k < lim)
    begin
      cyc(1);
      k++;
    end
    if ((tun ? |tuning : callOut[ch]) !== v)
    begin
      check(tun ? |tuning : callOut[ch], v);
      print_verdict();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    cyc(10);
    srst = 1'h0;
    chEnable = 2'h3;
    cyc(6);
    check({tuning, callOut}, 4'hF);
    wait_for(0, 1'h0, 450, 1'h1);
    cyc(4);
    check({tuning, callOut}, 4'h0);
    $display("tune test done");
    delaySec = 10'h002;
    extendQtr = 12'h003;
    cnt[0] = 16'h0D00;
    cyc(50);
    check(callOut[0], 1'h0);
    wait_for(0, 1'h1, 60, 1'h0);
    check(callOut[0], 1'h1);
    cnt[0] = 16'h1000;
    cyc(15);
    cnt[0] = 16'h0D00;
    cyc(40);
    check(callOut[0], 1'h1);
    cnt[0] = 16'h1000;
    cyc(15);
    check(callOut[0], 1'h1);
    wait_for(0, 1'h0, 60, 1'h0);
    $display("timing test done");
    delaySec = 10'h000;
    extendQtr = 12'h000;
    cnt[1] = 16'h0FF0;
    cyc(30);
    check(callOut[1], 1'h0);
    sensLevel = 6'h38;
    wait_for(1, 1'h1, 30, 1'h0);
    check(callOut[1], 1'h1);
    chEnable = 2'h0;
    cyc(5);
    check({tuning, callOut}, 4'h0);
    cnt[1] = 16'h1000;
    sensLevel = 6'h00;
    chEnable = 2'h3;
    cyc(5);
    wait_for(0, 1'h0, 450, 1'h1);
    $display("panel test done");
    openFault = 2'h1;
    cyc(5);
    check({faultInd[0], callOut[0]}, 2'h3);
    openFault = 2'h0;
    wait_for(0, 1'h0, 450, 1'h1);
    check(faultInd, 2'h1);
    manualReset = 1'h1;
    cyc(4);
    manualReset = 1'h0;
    cyc(2);
    check(faultInd, 2'h0);
    groundFault = 2'h2;
    cnt[0] = 16'h0B00;
    cyc(10);
    check(faultInd, 2'h3);
    groundFault = 2'h0;
    cnt[0] = 16'h1000;
    wait_for(0, 1'h0, 450, 1'h1);
    manualReset = 1'h1;
    cyc(4);
    manualReset = 1'h0;
    cyc(2);
    check(faultInd, 2'h0);
    $display("fault test done");
    // power loss and class 2 hold
    chEnable = 2'h1;
    powerOk = 1'h0;
    cyc(6);
    check(callOut, 2'h1);
    powerOk = 1'h1;
    chEnable = 2'h3;
    classSel = 2'h1;
    wait_for(0, 1'h0, 450, 1'h1);
    cnt[0] = 16'h0D00;
    cnt[1] = 16'h0D00;
    wait_for(1, 1'h1, 20, 1'h0);
    cyc(9585);
    check({tuning, callOut}, 4'h3);
    wait_for(1, 1'h0, 200, 1'h0);
    check({tuning[0], callOut[0]}, 2'h1);
    check(callCount == 8'h00, 1'h0);
    $display("power and hold test done");
    print_verdict();
  end
endmodule
bind loop_detector_channel_timing loop_detector_sva #(.TICK_CYCLES(TICK_CYCLES)) i_loop_detector_sva (
  .ref_clk(ref_clk), .srst(srst), .measValid(measValid), .chEnable(chEnable),
  .openFault(openFault), .groundFault(groundFault), .powerOk(powerOk), .manualReset(manualReset),
  .callOut(callOut), .faultInd(faultInd), .tuning(tuning), .scanSel(scanSel));
